// ===== hdl/pmoc_output_ctrl.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pmoc_output_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic standby_in,
  input wire logic [pmoc_pkg::PMOC_ADDR_W-1:0] addr_in,
  input wire logic [pmoc_pkg::PMOC_DATA_W-1:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic [1:0] combo_sel_in,
  input wire logic capture_a_ch1_in,
  input wire logic [5:0] pwm_wave_in,
  input wire logic [5:0] io_drive_req_in,
  output logic [pmoc_pkg::PMOC_DATA_W-1:0] rd_data_out,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  output logic irq_out
);
  import pmoc_pkg::*;

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic [5:0] oen_q;
  logic [5:0] oen_d;
  logic trig_off_q;
  logic trig_off_d;
  logic pol_a_q;
  logic pol_a_d;
  logic pol_b_q;
  logic pol_b_d;
  logic [0:0] irq_stat_q;
  logic [0:0] irq_stat_d;
  logic [0:0] irq_mask_q;
  logic [0:0] irq_mask_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic irq_q;
  logic irq_d;

  // --------------------------------------------------------------------------
  // Address decode and mode decode.
  // --------------------------------------------------------------------------
  wire logic wr_ome;
  wire logic wr_otpc;
  wire logic wr_stat;
  wire logic wr_mask;
  wire logic combined;
  wire logic trig_hit;
  wire logic [7:0] ome_view;
  wire logic [7:0] otpc_view;
  wire logic [7:0] rd_mux;
  pmoc_combo_t combo_mode;

  // Register strobes decoded from the plain port.
  assign wr_ome = wr_strobe_in && (addr_in == PMOC_OFS_OME);
  assign wr_otpc = wr_strobe_in && (addr_in == PMOC_OFS_OTPC);
  assign wr_stat = wr_strobe_in && (addr_in == PMOC_OFS_IRQ_STAT);
  assign wr_mask = wr_strobe_in && (addr_in == PMOC_OFS_IRQ_MASK);

  // The mode code is decoded once so both groups of controls see one answer.
  assign combo_mode = pmoc_combo_t'(combo_sel_in);
  logic combined_sel;
  always_comb begin
    unique case (combo_mode)
      PMOC_COMPLEMENTARY: combined_sel = 1'b1;
      PMOC_RESET_SYNC: combined_sel = 1'b1;
      PMOC_NORMAL_0: combined_sel = 1'b0;
      PMOC_NORMAL_1: combined_sel = 1'b0;
    endcase
  end
  assign combined = combined_sel;

  // The capture event only shuts the pins down while armed in a combined mode.
  assign trig_hit = capture_a_ch1_in && !trig_off_q && combined;

  // Read views; reserved positions are forced to one, never stored.
  assign ome_view = PMOC_OME_RSVD | {2'b00, oen_q};
  assign otpc_view = PMOC_OTPC_RSVD
                     | ({7'h00, trig_off_q} << PMOC_TRIG_OFF_BIT)
                     | ({7'h00, pol_a_q} << PMOC_POL_A_BIT)
                     | ({7'h00, pol_b_q} << PMOC_POL_B_BIT);
  assign rd_mux = (addr_in == PMOC_OFS_OME) ? ome_view :
                  (addr_in == PMOC_OFS_OTPC) ? otpc_view :
                  (addr_in == PMOC_OFS_IRQ_STAT) ? {7'h00, irq_stat_q} :
                  (addr_in == PMOC_OFS_IRQ_MASK) ? {7'h00, irq_mask_q} : 8'h00;

  // --------------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------------
  // Standby restores reset values; the trigger clear is applied after the
  // software write so it wins a same-cycle collision.
  always_comb begin
    oen_d = oen_q;
    if (wr_ome) begin
      oen_d = wr_data_in[5:0];
    end
    if (trig_hit) begin
      oen_d = 6'h00;
    end
    if (standby_in) begin
      oen_d = PMOC_OME_RESET[5:0];
    end
  end

  // Only the three live control bits are stored; writes to reserved ones drop.
  assign trig_off_d = standby_in ? PMOC_OTPC_RESET[PMOC_TRIG_OFF_BIT] :
                      wr_otpc ? wr_data_in[PMOC_TRIG_OFF_BIT] : trig_off_q;
  assign pol_a_d = standby_in ? PMOC_OTPC_RESET[PMOC_POL_A_BIT] :
                   wr_otpc ? wr_data_in[PMOC_POL_A_BIT] : pol_a_q;
  assign pol_b_d = standby_in ? PMOC_OTPC_RESET[PMOC_POL_B_BIT] :
                   wr_otpc ? wr_data_in[PMOC_POL_B_BIT] : pol_b_q;

  // Write-one-to-clear status; a new shutdown in the clearing cycle survives.
  assign irq_stat_d = (irq_stat_q & ~(wr_stat ? wr_data_in[0:0] : 1'b0)) | trig_hit;
  assign irq_mask_d = wr_mask ? wr_data_in[0:0] : irq_mask_q;
  assign irq_d = |(irq_stat_d & irq_mask_d);

  // Read data stands only in the cycle after the strobe.
  assign rd_data_d = rd_strobe_in ? rd_mux : 8'h00;

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  // Control registers, all ones from reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oen_q <= PMOC_OME_RESET[5:0];
      trig_off_q <= PMOC_OTPC_RESET[PMOC_TRIG_OFF_BIT];
      pol_a_q <= PMOC_OTPC_RESET[PMOC_POL_A_BIT];
      pol_b_q <= PMOC_OTPC_RESET[PMOC_POL_B_BIT];
    end else begin
      oen_q <= oen_d;
      trig_off_q <= trig_off_d;
      pol_a_q <= pol_a_d;
      pol_b_q <= pol_b_d;
    end
  end

  // Interrupt state and read port.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= PMOC_IRQ_STAT_RESET;
      irq_mask_q <= PMOC_IRQ_MASK_RESET;
      irq_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_out = rd_data_q;
  assign irq_out = irq_q;

  // --------------------------------------------------------------------------
  // Pin gate.
  // --------------------------------------------------------------------------
  pmoc_gate_if gif ();

  // Controls feed the gate directly; the gate registers the pins once more.
  assign gif.enable = oen_q;
  assign gif.wave = pwm_wave_in;
  assign gif.drive_req = io_drive_req_in;
  assign gif.combined = combined;
  assign gif.pol_a = pol_a_q;
  assign gif.pol_b = pol_b_q;

  pmoc_pin_gate u_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .gif(gif),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out)
  );

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  trig_clears_all_a: assert property (
    trig_hit && !standby_in |=> oen_q == 6'h00)
    else $error("Trigger did not clear the enable bits.");

  trig_beats_write_a: assert property (
    trig_hit && wr_ome && !standby_in |=> ome_view == 8'hc0)
    else $error("Software write beat the trigger clear.");

  trig_disarmed_a: assert property (
    capture_a_ch1_in && trig_off_q && !wr_ome && !standby_in |=> $stable(oen_q))
    else $error("Disarmed trigger changed the enable bits.");

  normal_mode_a: assert property (
    capture_a_ch1_in && combo_sel_in[1] == 1'b0 && !wr_ome && !standby_in
    |=> $stable(oen_q) ##1 ($past(combo_sel_in[1]) || pin_out == $past(pwm_wave_in)))
    else $error("Normal mode reacted to trigger or polarity.");

  standby_restore_a: assert property (
    standby_in |=> otpc_view == 8'hff && ome_view == 8'hff)
    else $error("Standby did not restore all ones.");

  otpc_reserved_a: assert property (
    rd_strobe_in && addr_in == PMOC_OFS_OTPC |=> (rd_data_out & 8'hec) == 8'hec)
    else $error("Control reserved bits did not read as one.");

  ome_reserved_a: assert property (
    rd_strobe_in && addr_in == PMOC_OFS_OME
    |=> rd_data_out[7:6] == 2'b11 && rd_data_out[5:0] == $past(oen_q))
    else $error("Enable register read back wrong.");

  enable_gates_pin_a: assert property (
    1'b1 |=> (pin_oe_out & ~$past(oen_q)) == 6'h00)
    else $error("Pin driven with its enable bit clear.");

  group_a_invert_a: assert property (
    combined && !pol_a_q |=> pin_out[PMOC_PIN_CH3_A] == !$past(pwm_wave_in[0]))
    else $error("Group A output not inverted.");

  group_b_invert_a: assert property (
    combined && !pol_b_q |=> pin_out[PMOC_PIN_EXTRA_B] == !$past(pwm_wave_in[5]))
    else $error("Group B output not inverted.");

  combined_drive_a: assert property (
    combo_sel_in == 2'b11 && oen_q == 6'h3f |=> pin_oe_out == 6'h3f)
    else $error("Combined mode did not drive all enabled pins.");

  irq_follow_a: assert property (
    trig_hit && irq_mask_q[0] && !wr_mask |=> irq_out && irq_stat_q[0])
    else $error("Shutdown did not raise the interrupt.");

  shutdown_cov: cover property (
    trig_hit ##1 oen_q == 6'h00 ##1 pin_oe_out == 6'h00);
  clear_collide_cov: cover property (trig_hit && wr_stat && wr_data_in[0]);
  invert_cov: cover property (combined && !pol_a_q && !pol_b_q && oen_q != 6'h00);
  normal_ignore_cov: cover property (capture_a_ch1_in && !combined && !trig_off_q);
  standby_cov: cover property (standby_in ##1 oen_q == 6'h3f);

endmodule
`default_nettype wire

// ===== hdl/pmoc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the output enable and polarity control block.
// ----------------------------------------------------------------------------
package pmoc_pkg;

  // Register address width and word width of the plain register port.
  localparam int unsigned PMOC_ADDR_W = 3;
  localparam int unsigned PMOC_DATA_W = 8;
  localparam int unsigned PMOC_PIN_N = 6;

  // Register offsets.
  localparam logic [2:0] PMOC_OFS_OME = 3'h0;
  localparam logic [2:0] PMOC_OFS_OTPC = 3'h1;
  localparam logic [2:0] PMOC_OFS_IRQ_STAT = 3'h2;
  localparam logic [2:0] PMOC_OFS_IRQ_MASK = 3'h3;

  // Reset values and the positions that always read as one.
  localparam logic [7:0] PMOC_OME_RESET = 8'hff;
  localparam logic [7:0] PMOC_OTPC_RESET = 8'hff;
  localparam logic [7:0] PMOC_OME_RSVD = 8'hc0;
  localparam logic [7:0] PMOC_OTPC_RSVD = 8'hec;
  localparam logic [0:0] PMOC_IRQ_STAT_RESET = 1'h0;
  localparam logic [0:0] PMOC_IRQ_MASK_RESET = 1'h0;

  // Field positions of the output trigger and polarity control register.
  localparam int unsigned PMOC_TRIG_OFF_BIT = 4;
  localparam int unsigned PMOC_POL_A_BIT = 1;
  localparam int unsigned PMOC_POL_B_BIT = 0;

  // Pin index order, shared by the enable bits and the pin vectors.
  localparam int unsigned PMOC_PIN_CH3_A = 0;
  localparam int unsigned PMOC_PIN_CH4_A = 1;
  localparam int unsigned PMOC_PIN_CH4_B = 2;
  localparam int unsigned PMOC_PIN_CH3_B = 3;
  localparam int unsigned PMOC_PIN_EXTRA_A = 4;
  localparam int unsigned PMOC_PIN_EXTRA_B = 5;

  // Pins whose polarity follows group A; the rest follow group B.
  localparam logic [5:0] PMOC_GROUP_A_MASK = 6'h07;

  // Combination mode codes.
  typedef enum logic [1:0] {
    PMOC_NORMAL_0 = 2'b00,
    PMOC_NORMAL_1 = 2'b01,
    PMOC_COMPLEMENTARY = 2'b10,
    PMOC_RESET_SYNC = 2'b11
  } pmoc_combo_t;

endpackage

// ===== hdl/pmoc_gate_if.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Control bundle from the register block to the pin gate.
// ----------------------------------------------------------------------------
interface pmoc_gate_if;
  logic [5:0] enable;
  logic [5:0] wave;
  logic [5:0] drive_req;
  logic combined;
  logic pol_a;
  logic pol_b;

  modport ctrl (output enable, output wave, output drive_req, output combined,
                output pol_a, output pol_b);
  modport gate (input enable, input wave, input drive_req, input combined,
                input pol_a, input pol_b);
endinterface
`default_nettype wire

// ===== hdl/pmoc_pin_gate.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Per-pin master gate and level inversion, registered at the pins.
// ----------------------------------------------------------------------------
module pmoc_pin_gate (
  input wire logic clk_in,
  input wire logic rst_in,
  pmoc_gate_if.gate gif,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out
);
  import pmoc_pkg::*;

  logic [5:0] pin_d;
  logic [5:0] oe_d;

  // Each pin is gated by its own enable bit; a cleared bit hands the pin back
  // to general-purpose I/O by dropping the drive, whatever the modes say.
  for (genvar i = 0; i < PMOC_PIN_N; i++) begin : g_pin
    wire logic pol_sel;
    wire logic invert;
    assign pol_sel = PMOC_GROUP_A_MASK[i] ? gif.pol_a : gif.pol_b;
    assign invert = gif.combined & ~pol_sel;
    assign oe_d[i] = gif.enable[i] & (gif.combined | gif.drive_req[i]);
    assign pin_d[i] = gif.wave[i] ^ invert;
  end

  // Registered pins keep the pads free of decode glitches.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= 6'h00;
      pin_oe_out <= 6'h00;
    end else begin
      pin_out <= pin_d;
      pin_oe_out <= oe_d;
    end
  end
endmodule
`default_nettype wire

// ===== tb/pmoc_pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Far side model: waveform source, pin drive requests and capture event.
// ----------------------------------------------------------------------------
module pmoc_pin_partner (
  input wire logic clk_in,
  output logic [5:0] wave_out,
  output logic [5:0] drive_req_out,
  output logic capture_out
);
  // Levels start quiet so that no pin is requested before the bench asks.
  initial begin
    wave_out = 6'h00;
    drive_req_out = 6'h00;
    capture_out = 1'b0;
  end
  // Levels change just after an edge, as the timer logic would change them.
  task automatic set_levels(input logic [5:0] wave, input logic [5:0] req);
    @(posedge clk_in);
    wave_out <= wave;
    drive_req_out <= req;
  endtask
  // The capture event is one cycle wide, as an edge detector produces it.
  task automatic fire();
    @(posedge clk_in);
    capture_out <= 1'b1;
    @(posedge clk_in);
    capture_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_pwm_output_enable_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_pwm_output_enable_control;
  import pmoc_pkg::*;
  logic clk_in;
  logic rst_in;
  logic standby_in;
  logic [2:0] addr_in;
  logic [7:0] wr_data_in;
  logic wr_strobe_in;
  logic rd_strobe_in;
  logic [1:0] combo_sel_in;
  wire logic capture_w;
  wire logic [5:0] wave_w;
  wire logic [5:0] req_w;
  logic [7:0] rd_data_out;
  logic [5:0] pin_out;
  logic [5:0] pin_oe_out;
  logic irq_out;
  logic [7:0] v;
  int bad_count;
  int n_checks;
  // ----------------------------------------------------------------------------
  // Block under test and its far side.
  // ----------------------------------------------------------------------------
  pmoc_output_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .standby_in(standby_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
    .rd_strobe_in(rd_strobe_in), .combo_sel_in(combo_sel_in), .capture_a_ch1_in(capture_w),
    .pwm_wave_in(wave_w), .io_drive_req_in(req_w), .rd_data_out(rd_data_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out), .irq_out(irq_out));
  pmoc_pin_partner FAR (.clk_in(clk_in), .wave_out(wave_w), .drive_req_out(req_w),
    .capture_out(capture_w));
  // ----------------------------------------------------------------------------
  // Bus cycles and helpers.
  // ----------------------------------------------------------------------------
  // A write is a single strobe cycle; the register holds it from the next edge.
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    @(posedge clk_in);
    wr_strobe_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    @(posedge clk_in);
    rd_strobe_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask
  // Pins lag a write by two edges; three leave margin without hiding a stuck path.
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // Mode code is a level from the mode logic, changed just after an edge.
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_in);
    combo_sel_in <= m;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  // All registers come out of reset at their documented values.
  task automatic t_reset_values();
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hff)
    // Read data stand for one cycle only and then fall back to zero.
    @(posedge clk_in);
    #1;
    `CHK(rd_data_out, 8'h00)
    bus_rd(PMOC_OFS_OTPC, v);
    `CHK(v, 8'hff)
    bus_rd(PMOC_OFS_IRQ_STAT, v);
    `CHK(v, 8'h00)
    bus_rd(PMOC_OFS_IRQ_MASK, v);
    `CHK(v, 8'h00)
    bus_rd(3'h6, v);
    `CHK(v, 8'h00)
  endtask
  // Zeros written to both control registers leave the fixed positions reading as one.
  task automatic t_reserved();
    bus_wr(PMOC_OFS_OTPC, 8'h00);
    bus_rd(PMOC_OFS_OTPC, v);
    `CHK(v, 8'hec)
    bus_wr(PMOC_OFS_OME, 8'h00);
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hc0)
  endtask
  // In both normal codes the armed trigger and inverting selects change nothing.
  task automatic t_normal();
    FAR.set_levels(6'h15, 6'h33);
    bus_wr(PMOC_OFS_OME, 8'h2e);
    bus_wr(PMOC_OFS_OTPC, 8'hec);
    for (int m = 0; m < 2; m++) begin
      set_mode(2'(m));
      settle();
      `CHK(pin_oe_out, 6'h22)
      `CHK(pin_out, 6'h15)
      FAR.fire();
      settle();
      bus_rd(PMOC_OFS_OME, v);
      `CHK(v, 8'hee)
    end
  endtask
  // Polarity groups and per-pin gating in both combined modes.
  task automatic t_combined();
    FAR.set_levels(6'h15, 6'h00);
    bus_wr(PMOC_OFS_OME, 8'hff);
    for (int m = 2; m < 4; m++) begin
      set_mode(2'(m));
      bus_wr(PMOC_OFS_OTPC, 8'hfc);
      settle();
      `CHK(pin_out, 6'h2a)
      bus_wr(PMOC_OFS_OTPC, 8'hfe);
      settle();
      `CHK(pin_out, 6'h2d)
      bus_wr(PMOC_OFS_OTPC, 8'hfd);
      settle();
      `CHK(pin_out, 6'h12)
      for (int i = 0; i < 6; i++) begin
        bus_wr(PMOC_OFS_OME, {2'b11, 6'h3f ^ (6'h01 << i)});
        settle();
        `CHK(pin_oe_out, 6'h3f ^ (6'h01 << i))
      end
      bus_wr(PMOC_OFS_OME, 8'hff);
    end
  endtask
  // Trigger ignored while disabled, then clears all enables and raises the flag.
  task automatic t_trigger();
    bus_wr(PMOC_OFS_IRQ_MASK, 8'h01);
    bus_rd(PMOC_OFS_IRQ_MASK, v);
    `CHK(v, 8'h01)
    bus_wr(PMOC_OFS_OTPC, 8'hff);
    FAR.fire();
    settle();
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hff)
    `CHK(irq_out, 1'b0)
    bus_wr(PMOC_OFS_OTPC, 8'hef);
    FAR.fire();
    settle();
    `CHK(irq_out, 1'b1)
    `CHK(pin_oe_out, 6'h00)
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hc0)
    bus_wr(PMOC_OFS_IRQ_STAT, 8'h01);
    settle();
    `CHK(irq_out, 1'b0)
    bus_wr(PMOC_OFS_OME, 8'hff);
    bus_wr(PMOC_OFS_IRQ_MASK, 8'h00);
    FAR.fire();
    settle();
    `CHK(irq_out, 1'b0)
    bus_rd(PMOC_OFS_IRQ_STAT, v);
    `CHK(v, 8'h01)
  endtask
  // A write landing on the trigger edge loses to the hardware clear.
  task automatic t_collide();
    fork
      bus_wr(PMOC_OFS_OME, 8'hff);
      FAR.fire();
    join
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hc0)
  endtask
  // Standby restores both control registers but leaves the event flag alone.
  task automatic t_standby();
    @(posedge clk_in);
    standby_in <= 1'b1;
    @(posedge clk_in);
    standby_in <= 1'b0;
    bus_rd(PMOC_OFS_OME, v);
    `CHK(v, 8'hff)
    bus_rd(PMOC_OFS_OTPC, v);
    `CHK(v, 8'hff)
    bus_rd(PMOC_OFS_IRQ_STAT, v);
    `CHK(v, 8'h01)
  endtask
  // Verdict and end of run.
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Free-running clock at 125 MHz.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // A hang counts as a mismatch and ends the run through the verdict.
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // Main sequence.
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst_in = 1'b1;
    standby_in = 1'b0;
    addr_in = 3'h0;
    wr_data_in = 8'h00;
    wr_strobe_in = 1'b0;
    rd_strobe_in = 1'b0;
    combo_sel_in = 2'b00;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset_values();
    t_reserved();
    t_normal();
    t_combined();
    t_trigger();
    t_collide();
    t_standby();
    finish_test();
  end
endmodule
`default_nettype wire
